// *** inc/bf16_dp_pkg.sv ***
// Purpose: shared types and constants for the brain-float convert and dot datapath
// Assumes: one processor clock, operands read from register files with one cycle latency
// Notes: vector length is a module parameter of the datapath
package bf16_dp_pkg;

    typedef enum logic [1:0] {
        OP_PACKED_CVT = 2'h0,
        OP_INTERLEAVED_CVT = 2'h1,
        OP_DOT = 2'h2
    } op_e;

    typedef struct packed {
        op_e op;
        logic four_group;
        logic [1:0] select_reg_field;
        logic [3:0] first_source_field;
        logic [3:0] second_source_field;
        logic [4:0] dest_field;
        logic [2:0] vector_offset_field;
        logic [1:0] pair_index_field;
    } req_s;

    typedef struct packed {
        logic streaming_en;
        logic array_en;
        logic v2_impl;
    } feat_s;

    typedef struct packed {
        logic invalid;
        logic overflow;
        logic underflow;
        logic inexact;
        logic in_denorm;
    } fp_flags_s;

    localparam int VL_DEFAULT = 128;
    localparam int ELEM_BITS = 32;
    localparam int HALF_BITS = 16;
    localparam int PAIRS_PER_SEG = 4;
    localparam int ZA_VEC_DIV = 8;
    localparam int GROUPS_TWO = 2;
    localparam int GROUPS_FOUR = 4;
    localparam int FLOAT_CONTROL_REGISTER_RM_LSB = 22;
    localparam int FLOAT_CONTROL_REGISTER_FZ_BIT = 24;
    localparam int FLOAT_CONTROL_REGISTER_DN_BIT = 25;
    localparam logic [1:0] RM_NEAREST = 2'h0;
    localparam logic [1:0] RM_PLUS = 2'h1;
    localparam logic [1:0] RM_MINUS = 2'h2;
    localparam logic [2:0] SEL_PREFIX = 3'h2;
    localparam logic [15:0] BF16_DNAN = 16'h7FC0;
    localparam logic [15:0] BF16_QUIET = 16'h0040;
    localparam logic [31:0] F32_DNAN = 32'h7FC00000;
    localparam logic [30:0] F32_INF_MAG = 31'h7F800000;

endpackage

// *** verilog/bf16_convert_lanes.sv ***
// Purpose: single to brain-float conversion of two source vectors
// Assumes: combinational, operands held stable by the caller
// Notes: flags are the OR over all lanes
module bf16_convert_lanes
    import bf16_dp_pkg::*;
#(
    parameter int VL = VL_DEFAULT
) (
    input wire logic [VL-1:0] src_a_i,
    input wire logic [VL-1:0] src_b_i,
    input wire logic [31:0] float_control_register_i,
    input wire logic interleave_i,
    output logic [VL-1:0] res_o,
    output fp_flags_s flags_o
);
    localparam int NE = VL / ELEM_BITS;

    function automatic logic [20:0] cvt(input logic [31:0] x, input logic [31:0] float_control_register);
        logic [1:0] rm;
        logic up;
        logic [15:0] r;
        fp_flags_s f;
        rm = float_control_register[FLOAT_CONTROL_REGISTER_RM_LSB +: 2];
        f = '0;
        up = 1'b0;
        r = x[31:16];
        if (x[30:23] == 8'hFF && x[22:0] != 23'h0) begin
            f.invalid = !x[22];
            r = float_control_register[FLOAT_CONTROL_REGISTER_DN_BIT] ? BF16_DNAN : (x[31:16] | BF16_QUIET);
        end else if (x[30:23] == 8'h00 && x[22:0] != 23'h0 && float_control_register[FLOAT_CONTROL_REGISTER_FZ_BIT]) begin
            f.in_denorm = 1'b1;
            r = {x[31], 15'h0};
        end else if (x[30:23] != 8'hFF) begin
            case (rm)
                RM_NEAREST: up = x[15] && (x[14:0] != 15'h0 || x[16]);
                RM_PLUS: up = !x[31] && x[15:0] != 16'h0;
                RM_MINUS: up = x[31] && x[15:0] != 16'h0;
                default: up = 1'b0;
            endcase
            r = x[31:16] + {15'h0, up};
            f.inexact = x[15:0] != 16'h0;
            f.overflow = r[14:7] == 8'hFF;
            f.underflow = r[14:7] == 8'h00 && f.inexact;
        end
        return {f, r};
    endfunction

    logic [NE-1:0][15:0] ra;
    logic [NE-1:0][15:0] rb;
    fp_flags_s [NE-1:0] fa;
    fp_flags_s [NE-1:0] fb;

    genvar e;
    generate
        for (e = 0; e < NE; e++) begin : g_lane
            assign {fa[e], ra[e]} = cvt(src_a_i[e*ELEM_BITS +: ELEM_BITS], float_control_register_i);
            assign {fb[e], rb[e]} = cvt(src_b_i[e*ELEM_BITS +: ELEM_BITS], float_control_register_i);
        end
    endgenerate

    always_comb begin
        res_o = '0;
        flags_o = '0;
        for (int i = 0; i < NE; i++) begin
            flags_o = flags_o | fa[i] | fb[i];
            if (interleave_i) begin
                res_o[(2*i)*HALF_BITS +: HALF_BITS] = ra[i];
                res_o[(2*i+1)*HALF_BITS +: HALF_BITS] = rb[i];
            end else begin
                res_o[i*HALF_BITS +: HALF_BITS] = ra[i];
                res_o[(NE+i)*HALF_BITS +: HALF_BITS] = rb[i];
            end
        end
    end

endmodule

// *** verilog/bf16_dot_lanes.sv ***
// Purpose: brain-float pair dot product by indexed element, added to accumulator lanes
// Assumes: combinational, operands held stable by the caller
// Notes: denormals flush to zero, sums truncate, NaN results are the default NaN
module bf16_dot_lanes
    import bf16_dp_pkg::*;
#(
    parameter int VL = VL_DEFAULT
) (
    input wire logic [VL-1:0] src_a_i,
    input wire logic [VL-1:0] src_b_i,
    input wire logic [VL-1:0] acc_i,
    input wire logic [1:0] index_i,
    output logic [VL-1:0] res_o
);
    localparam int NE = VL / ELEM_BITS;

    function automatic logic [31:0] bmul(input logic [15:0] x, input logic [15:0] y);
        logic [15:0] m;
        logic s;
        int e;
        s = x[15] ^ y[15];
        if ((x[14:7] == 8'hFF && x[6:0] != 7'h0) || (y[14:7] == 8'hFF && y[6:0] != 7'h0))
            return F32_DNAN;
        if (x[14:7] == 8'hFF || y[14:7] == 8'hFF)
            return (x[14:0] == 15'h0 || y[14:0] == 15'h0) ? F32_DNAN : {s, F32_INF_MAG};
        if (x[14:7] == 8'h00 || y[14:7] == 8'h00)
            return {s, 31'h0};
        m = {1'b1, x[6:0]} * {1'b1, y[6:0]};
        e = int'(x[14:7]) + int'(y[14:7]) - 127 + int'(m[15]);
        if (e >= 255)
            return {s, F32_INF_MAG};
        if (e <= 0)
            return {s, 31'h0};
        return m[15] ? {s, 8'(e), m[14:0], 8'h0} : {s, 8'(e), m[13:0], 9'h0};
    endfunction

    function automatic logic [31:0] fadd(input logic [31:0] a, input logic [31:0] b);
        logic [31:0] x;
        logic [31:0] y;
        logic [48:0] mx;
        logic [48:0] my;
        logic [48:0] s;
        logic [48:0] t;
        int p;
        int e;
        x = (a[30:0] >= b[30:0]) ? a : b;
        y = (a[30:0] >= b[30:0]) ? b : a;
        if (x[30:23] == 8'hFF)
            return (x[22:0] != 23'h0 || (y[30:0] == x[30:0] && y[31] != x[31])) ? F32_DNAN : x;
        if (x[30:23] == 8'h00)
            return {x[31] & y[31], 31'h0};
        if (y[30:23] == 8'h00)
            return x;
        mx = {2'b01, x[22:0], 24'h0};
        my = {2'b01, y[22:0], 24'h0} >> (x[30:23] - y[30:23]);
        s = (x[31] == y[31]) ? mx + my : mx - my;
        if (s == 49'h0)
            return 32'h0;
        p = 0;
        for (int i = 0; i < 49; i++)
            if (s[i])
                p = i;
        e = int'(x[30:23]) + p - 47;
        if (e >= 255)
            return {x[31], F32_INF_MAG};
        if (e <= 0)
            return {x[31], 31'h0};
        t = s << (48 - p);
        return {x[31], 8'(e), t[47:25]};
    endfunction

    genvar e;
    generate
        for (e = 0; e < NE; e++) begin : g_lane
            localparam int SB = e - (e % PAIRS_PER_SEG);
            logic [31:0] a;
            logic [31:0] b;
            logic [31:0] pr;
            assign a = src_a_i[e*ELEM_BITS +: ELEM_BITS];
            assign b = src_b_i[(SB + int'(index_i))*ELEM_BITS +: ELEM_BITS];
            assign pr = fadd(bmul(a[15:0], b[15:0]), bmul(a[31:16], b[31:16]));
            assign res_o[e*ELEM_BITS +: ELEM_BITS] = fadd(acc_i[e*ELEM_BITS +: ELEM_BITS], pr);
        end
    endgenerate

endmodule

// *** verilog/bf16_convert_dot_datapath.sv ***
// Purpose: sequencer for packed and interleaved conversion and grouped pair dot product
// Assumes: register file reads return data in the cycle after the read enable
// Notes: one operation at a time; requests while busy are ignored
//
// Design decisions made here: the address map and the address-and-strobe port.
module bf16_convert_dot_datapath
    import bf16_dp_pkg::*;
#(
    parameter int VL = VL_DEFAULT
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic req_valid_i,
    input wire req_s req_i,
    input wire feat_s feat_i,
    input wire logic [31:0] float_control_register_i,
    input wire logic [63:0] gpr_rd_data_i,
    input wire logic [VL-1:0] z_rd_data_i,
    input wire logic [VL-1:0] za_rd_data_i,
    output logic busy_o,
    output logic done_o,
    output logic undef_o,
    output logic trap_o,
    output fp_flags_s flags_o,
    output logic gpr_rd_en_o,
    output logic [4:0] gpr_rd_addr_o,
    output logic z_rd_en_o,
    output logic [4:0] z_rd_addr_o,
    output logic za_rd_en_o,
    output logic [$clog2(VL/ZA_VEC_DIV)-1:0] za_rd_addr_o,
    output logic za_wr_en_o,
    output logic [$clog2(VL/ZA_VEC_DIV)-1:0] za_wr_addr_o,
    output logic z_wr_en_o,
    output logic [4:0] z_wr_addr_o,
    output logic [VL-1:0] wr_data_o
);
    localparam int NVEC = VL / ZA_VEC_DIV;
    localparam int AW = $clog2(NVEC);

    typedef enum logic [9:0] {
        ST_IDLE = 10'h001,
        ST_SEL = 10'h002,
        ST_ZM = 10'h004,
        ST_ZN = 10'h008,
        ST_ACC = 10'h010,
        ST_CVA = 10'h020,
        ST_CVB = 10'h040,
        ST_CALC = 10'h080,
        ST_EXEC = 10'h100,
        ST_WR = 10'h200
    } state_e;

    typedef struct packed {
        state_e st;
        req_s req;
        logic [31:0] float_control_register;
        logic [AW-1:0] vec;
        logic [1:0] grp;
        logic [VL-1:0] opa;
        logic [VL-1:0] opb;
        logic [VL-1:0] acc;
        logic busy;
        logic done;
        logic undef;
        logic trap;
        fp_flags_s flags;
        logic gpr_rd_en;
        logic [4:0] gpr_rd_addr;
        logic z_rd_en;
        logic [4:0] z_rd_addr;
        logic za_rd_en;
        logic [AW-1:0] za_rd_addr;
        logic za_wr_en;
        logic [AW-1:0] za_wr_addr;
        logic z_wr_en;
        logic [4:0] z_wr_addr;
        logic [VL-1:0] wr_data;
    } state_s;

    state_s q;
    state_s d;

    logic [VL-1:0] cvt_res;
    fp_flags_s cvt_flags;
    logic [VL-1:0] dot_res;
    logic [32:0] vsum;

    function automatic logic [4:0] src_base(input req_s r);
        if (r.op == OP_DOT && r.four_group)
            return {r.first_source_field[2:0], 2'b00};
        return {r.first_source_field, 1'b0};
    endfunction

    function automatic logic [AW-1:0] stride(input req_s r);
        return r.four_group ? AW'(NVEC / GROUPS_FOUR) : AW'(NVEC / GROUPS_TWO);
    endfunction

    function automatic logic [1:0] last_grp(input req_s r);
        return r.four_group ? 2'(GROUPS_FOUR - 1) : 2'(GROUPS_TWO - 1);
    endfunction

    bf16_convert_lanes #(
        .VL(VL)
    ) u_cvt (
        .src_a_i(q.opa),
        .src_b_i(q.opb),
        .float_control_register_i(q.float_control_register),
        .interleave_i(q.req.op == OP_INTERLEAVED_CVT),
        .res_o(cvt_res),
        .flags_o(cvt_flags)
    );

    bf16_dot_lanes #(
        .VL(VL)
    ) u_dot (
        .src_a_i(q.opa),
        .src_b_i(q.opb),
        .acc_i(q.acc),
        .index_i(q.req.pair_index_field),
        .res_o(dot_res)
    );

    assign vsum = {1'b0, gpr_rd_data_i[31:0]} + {30'h0, q.req.vector_offset_field};

    always_comb begin
        d = q;
        d.done = 1'b0;
        d.undef = 1'b0;
        d.trap = 1'b0;
        d.gpr_rd_en = 1'b0;
        d.z_rd_en = 1'b0;
        d.za_rd_en = 1'b0;
        d.za_wr_en = 1'b0;
        d.z_wr_en = 1'b0;
        case (q.st)
            ST_IDLE: begin
                if (req_valid_i) begin
                    d.req = req_i;
                    d.float_control_register = float_control_register_i;
                    d.grp = 2'h0;
                    d.flags = '0;
                    if (!feat_i.v2_impl) begin
                        d.undef = 1'b1;
                    end else if (!feat_i.streaming_en ||
                                 (req_i.op == OP_DOT && !feat_i.array_en)) begin
                        d.trap = 1'b1;
                    end else if (req_i.op == OP_DOT) begin
                        d.gpr_rd_en = 1'b1;
                        d.gpr_rd_addr = {SEL_PREFIX, req_i.select_reg_field};
                        d.st = ST_SEL;
                    end else begin
                        d.z_rd_en = 1'b1;
                        d.z_rd_addr = src_base(req_i);
                        d.st = ST_CVA;
                    end
                end
            end
            ST_SEL: begin
                d.z_rd_en = 1'b1;
                d.z_rd_addr = {1'b0, q.req.second_source_field};
                d.st = ST_ZM;
            end
            ST_ZM: begin
                d.vec = vsum[AW-1:0] & (stride(q.req) - AW'(1));
                d.z_rd_en = 1'b1;
                d.z_rd_addr = src_base(q.req);
                d.st = ST_ZN;
            end
            ST_ZN: begin
                if (q.grp == 2'h0) begin
                    d.opb = z_rd_data_i;
                end
                d.za_rd_en = 1'b1;
                d.za_rd_addr = q.vec;
                d.st = ST_ACC;
            end
            ST_ACC: begin
                d.opa = z_rd_data_i;
                d.st = ST_CALC;
            end
            ST_CVA: begin
                d.z_rd_en = 1'b1;
                d.z_rd_addr = src_base(q.req) + 5'h1;
                d.st = ST_CVB;
            end
            ST_CVB: begin
                d.opa = z_rd_data_i;
                d.st = ST_CALC;
            end
            ST_CALC: begin
                if (q.req.op == OP_DOT) begin
                    d.acc = za_rd_data_i;
                end else begin
                    d.opb = z_rd_data_i;
                end
                d.st = ST_EXEC;
            end
            ST_EXEC: begin
                if (q.req.op == OP_DOT) begin
                    d.wr_data = dot_res;
                    d.za_wr_en = 1'b1;
                    d.za_wr_addr = q.vec;
                end else begin
                    d.wr_data = cvt_res;
                    d.flags = cvt_flags;
                    d.z_wr_en = 1'b1;
                    d.z_wr_addr = q.req.dest_field;
                end
                d.st = ST_WR;
            end
            ST_WR: begin
                if (q.req.op == OP_DOT && q.grp != last_grp(q.req)) begin
                    d.grp = q.grp + 2'h1;
                    d.vec = q.vec + stride(q.req);
                    d.z_rd_en = 1'b1;
                    d.z_rd_addr = src_base(q.req) + {3'h0, d.grp};
                    d.st = ST_ZN;
                end else begin
                    d.done = 1'b1;
                    d.st = ST_IDLE;
                end
            end
            default: begin
                d.st = ST_IDLE;
            end
        endcase
        d.busy = d.st != ST_IDLE;
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            q <= '0;
            q.st <= ST_IDLE;
        end else begin
            q <= d;
        end
    end

    assign busy_o = q.busy;
    assign done_o = q.done;
    assign undef_o = q.undef;
    assign trap_o = q.trap;
    assign flags_o = q.flags;
    assign gpr_rd_en_o = q.gpr_rd_en;
    assign gpr_rd_addr_o = q.gpr_rd_addr;
    assign z_rd_en_o = q.z_rd_en;
    assign z_rd_addr_o = q.z_rd_addr;
    assign za_rd_en_o = q.za_rd_en;
    assign za_rd_addr_o = q.za_rd_addr;
    assign za_wr_en_o = q.za_wr_en;
    assign za_wr_addr_o = q.za_wr_addr;
    assign z_wr_en_o = q.z_wr_en;
    assign z_wr_addr_o = q.z_wr_addr;
    assign wr_data_o = q.wr_data;

endmodule

// *** testbench/bf16_convert_dot_datapath_checker.sv ***
// Purpose: port checks for the convert and dot datapath
// Assumes: cycle figures of the sequencer
// Notes: bound from the bench top file
module bf16_convert_dot_datapath_checker
    import bf16_dp_pkg::*;
#(
    parameter int VL = VL_DEFAULT
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic req_valid_i,
    input wire req_s req_i,
    input wire feat_s feat_i,
    input wire logic [31:0] float_control_register_i,
    input wire logic [63:0] gpr_rd_data_i,
    input wire logic [VL-1:0] z_rd_data_i,
    input wire logic [VL-1:0] za_rd_data_i,
    input wire logic busy_o,
    input wire logic done_o,
    input wire logic undef_o,
    input wire logic trap_o,
    input wire fp_flags_s flags_o,
    input wire logic gpr_rd_en_o,
    input wire logic [4:0] gpr_rd_addr_o,
    input wire logic z_rd_en_o,
    input wire logic [4:0] z_rd_addr_o,
    input wire logic za_rd_en_o,
    input wire logic [$clog2(VL/ZA_VEC_DIV)-1:0] za_rd_addr_o,
    input wire logic za_wr_en_o,
    input wire logic [$clog2(VL/ZA_VEC_DIV)-1:0] za_wr_addr_o,
    input wire logic z_wr_en_o,
    input wire logic [4:0] z_wr_addr_o,
    input wire logic [VL-1:0] wr_data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int AW = $clog2(VL / ZA_VEC_DIV);
    logic take, ok, cvt_go, dot_go, seen_q, four_q;
    logic [4:0] base_q;
    logic [AW-1:0] last_q, stride;
    assign take = req_valid_i && !busy_o;
    assign ok = take && feat_i.v2_impl && feat_i.streaming_en;
    assign cvt_go = ok && req_i.op != OP_DOT;
    assign dot_go = ok && req_i.op == OP_DOT && feat_i.array_en;
    assign stride = four_q ? AW'(VL / 32) : AW'(VL / 16);
    // Operation base and last array write
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            base_q <= 5'h0;
            four_q <= 1'h0;
            seen_q <= 1'h0;
            last_q <= '0;
        end else if (dot_go) begin
            base_q <= req_i.four_group ? {req_i.first_source_field[2:0], 2'h0}
                                       : {req_i.first_source_field, 1'h0};
            four_q <= req_i.four_group;
            seen_q <= 1'h0;
        end else if (za_wr_en_o) begin
            last_q <= za_wr_addr_o;
            seen_q <= 1'h1;
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);
    a_undef_pulse: assert property (
        take && !feat_i.v2_impl |-> ##1 (undef_o && !trap_o && !done_o)) else $error("no undef");
    a_trap_no_write: assert property (
        take && feat_i.v2_impl && !feat_i.streaming_en |-> ##1 trap_o
        ##1 (!z_wr_en_o && !za_wr_en_o)[*5]) else $error("trap or write");
    a_array_trap: assert property (
        ok && req_i.op == OP_DOT && !feat_i.array_en |-> ##1 trap_o) else $error("no trap");
    a_cvt_reads: assert property (
        cvt_go |-> ##1 (z_rd_en_o && z_rd_addr_o == {$past(req_i.first_source_field), 1'h0})
        ##1 (z_rd_en_o && z_rd_addr_o == {$past(req_i.first_source_field, 2), 1'h1}))
        else $error("cvt reads");
    a_cvt_write: assert property (
        cvt_go |-> ##5 (z_wr_en_o && z_wr_addr_o == $past(req_i.dest_field, 5)) ##1 done_o)
        else $error("cvt write");
    a_sel_read: assert property (
        dot_go |-> ##1 (gpr_rd_en_o && gpr_rd_addr_o == {SEL_PREFIX, $past(req_i.select_reg_field)}))
        else $error("select read");
    a_dot_sources: assert property (
        dot_go |-> ##2 (z_rd_en_o && z_rd_addr_o == {1'h0, $past(req_i.second_source_field, 2)})
        ##1 (z_rd_en_o && z_rd_addr_o == base_q)) else $error("dot reads");
    a_dot_two_done: assert property (
        dot_go && !req_i.four_group |-> ##1 (busy_o && !done_o)[*8] ##5 done_o)
        else $error("dot done");
    a_vec_modulo: assert property (
        za_wr_en_o && !seen_q |-> za_wr_addr_o < stride) else $error("vector modulo");
    a_group_stride: assert property (
        za_wr_en_o && seen_q |-> za_wr_addr_o == AW'(last_q + stride)) else $error("stride");
    c_dot_four: cover property (dot_go && req_i.four_group);
    c_interleave: cover property (cvt_go && req_i.op == OP_INTERLEAVED_CVT);
    c_trap: cover property (trap_o);
endmodule

// *** testbench/tb_bf16_convert_dot_datapath.sv ***
// Purpose: self-checking bench for the convert and dot datapath
// Assumes: VL of 128, register files modelled as arrays here
// Notes: read data stand one cycle, then show their inverse
module tb_bf16_convert_dot_datapath
    import bf16_dp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int VL = 128;
    localparam int AW = $clog2(VL / ZA_VEC_DIV);
    localparam logic [15:0] BV [4] = '{16'h3F80, 16'h4000, 16'h4080, 16'h4100};
    localparam logic [31:0] SUMS [4] = '{32'h40A00000, 32'h40C00000, 32'h41000000, 32'h41400000};
    logic clk_i = 1'h0;
    logic sys_rst_i = 1'h1;
    logic req_valid_i = 1'h0;
    req_s req_i = '0;
    feat_s feat_i = 3'h7;
    logic [31:0] float_control_register_i = 32'h0;
    logic [63:0] gpr_rd_data_i = 64'h0;
    logic [VL-1:0] z_rd_data_i = '0;
    logic [VL-1:0] za_rd_data_i = '0;
    logic busy_o, done_o, undef_o, trap_o, gpr_rd_en_o, z_rd_en_o, za_rd_en_o, za_wr_en_o, z_wr_en_o;
    fp_flags_s flags_o;
    logic [4:0] gpr_rd_addr_o, z_rd_addr_o, z_wr_addr_o;
    logic [AW-1:0] za_rd_addr_o, za_wr_addr_o;
    logic [VL-1:0] wr_data_o;
    logic [63:0] gpr [32];
    logic [VL-1:0] zr [32];
    logic [VL-1:0] za [16];
    int n_mismatch = 0, samples_checked = 0, cycles = 0, n_zw = 0, n_zaw = 0;

`define CHK(got, exp) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) begin \
            n_mismatch++; \
            $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); \
        end \
    end

    bf16_convert_dot_datapath #(.VL(VL)) i_bf16_convert_dot_datapath (
        .clk_i, .sys_rst_i, .req_valid_i, .req_i, .feat_i, .float_control_register_i, .gpr_rd_data_i,
        .z_rd_data_i, .za_rd_data_i, .busy_o, .done_o, .undef_o, .trap_o, .flags_o,
        .gpr_rd_en_o, .gpr_rd_addr_o, .z_rd_en_o, .z_rd_addr_o, .za_rd_en_o, .za_rd_addr_o,
        .za_wr_en_o, .za_wr_addr_o, .z_wr_en_o, .z_wr_addr_o, .wr_data_o);

    always #4 clk_i = ~clk_i;

    // Register files: data one cycle after enable, writes captured
    always @(posedge clk_i) begin
        gpr_rd_data_i <= gpr_rd_en_o ? gpr[gpr_rd_addr_o] : ~gpr_rd_data_i;
        z_rd_data_i <= z_rd_en_o ? zr[z_rd_addr_o] : ~z_rd_data_i;
        za_rd_data_i <= za_rd_en_o ? za[za_rd_addr_o] : ~za_rd_data_i;
        if (z_wr_en_o) begin
            zr[z_wr_addr_o] <= wr_data_o;
            n_zw <= n_zw + 1;
        end
        if (za_wr_en_o) begin
            za[za_wr_addr_o] <= wr_data_o;
            n_zaw <= n_zaw + 1;
        end
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // One request, answer latency and kind checked
    task automatic issue(input req_s r, input feat_s f, input int exp_lat, input logic [2:0] exp_ans);
        int lat;
        lat = 0;
        req_i <= r;
        feat_i <= f;
        req_valid_i <= 1'h1;
        @(posedge clk_i);
        req_valid_i <= 1'h0;
        do begin
            @(negedge clk_i);
            lat++;
        end while (done_o !== 1'h1 && undef_o !== 1'h1 && trap_o !== 1'h1 && lat < 40);
        `CHK(lat, exp_lat)
        `CHK({done_o, undef_o, trap_o}, exp_ans)
        @(posedge clk_i);
    endtask

    task automatic t_convert();
        req_s r;
        logic [15:0] e2, e3;
        r = '0;
        r.first_source_field = 4'h1;
        r.dest_field = 5'h5;
        zr[2] = 128'h3F808001_C0408001_40000000_3F800000;
        zr[3] = 128'h7F800000_BF800000_00000000_41200000;
        for (int m = 0; m < 4; m++) begin
            float_control_register_i <= 32'(m) << FLOAT_CONTROL_REGISTER_RM_LSB;
            e3 = (m < 2) ? 16'h3F81 : 16'h3F80;
            e2 = (m == 0 || m == 2) ? 16'hC041 : 16'hC040;
            r.op = OP_PACKED_CVT;
            issue(r, 3'h5, 6, 3'h4);
            `CHK(zr[5], {64'h7F80BF80_00004120, e3, e2, 32'h40003F80})
            `CHK({flags_o.inexact, flags_o.invalid}, 2'h2)
            r.op = OP_INTERLEAVED_CVT;
            issue(r, 3'h7, 6, 3'h4);
            `CHK(zr[5], {16'h7F80, e3, 16'hBF80, e2, 64'h00004000_41203F80})
        end
    endtask

    task automatic t_dot(input logic four, input logic [1:0] sel, input int w,
                         input int off, input int first, input int second, input int idx);
        req_s r;
        int g, st, vec, base, nw;
        g = four ? GROUPS_FOUR : GROUPS_TWO;
        st = 16 / g;
        base = four ? first * 4 : first * 2;
        vec = (w + off) % st;
        r = '0;
        r.op = OP_DOT;
        r.four_group = four;
        r.select_reg_field = sel;
        r.first_source_field = 4'(first);
        r.second_source_field = 4'(second);
        r.vector_offset_field = 3'(off);
        r.pair_index_field = 2'(idx);
        gpr[{3'h2, sel}] = {32'hA5A5A5A5, 32'(w)};
        for (int p = 0; p < PAIRS_PER_SEG; p++) begin
            zr[second][32*p +: 32] = (p == idx) ? 32'h3F804040 : 32'h41004100;
        end
        for (int k = 0; k < g; k++) begin
            zr[base + k] = {4{BV[k], 16'h3F80}};
        end
        for (int k = 0; k < 16; k++) begin
            za[k] = {4{32'h3F800000}};
        end
        nw = n_zaw;
        issue(r, 3'h7, four ? 23 : 13, 3'h4);
        `CHK(flags_o, 5'h0)
        for (int k = 0; k < g; k++) begin
            `CHK(za[vec + k * st], {4{SUMS[k]}})
        end
        `CHK(n_zaw - nw, g)
    endtask

    task automatic t_faults();
        req_s r;
        int nz, na;
        r = '0;
        nz = n_zw;
        na = n_zaw;
        r.op = OP_DOT;
        issue(r, 3'h2, 1, 3'h2);
        issue(r, 3'h5, 1, 3'h1);
        r.op = OP_PACKED_CVT;
        issue(r, 3'h3, 1, 3'h1);
        `CHK({n_zw - nz, n_zaw - na}, 64'h0)
    endtask

    initial begin
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'h0;
        @(posedge clk_i);
        t_convert();
        for (int i = 0; i < 4; i++) begin
            t_dot(1'h0, 2'(i), 13 + 7 * i, 5, 2, 3, i);
        end
        t_dot(1'h1, 2'h2, 258, 7, 1, 15, 3);
        t_faults();
        print_verdict();
    end
endmodule

bind bf16_convert_dot_datapath bf16_convert_dot_datapath_checker #(.VL(VL)) i_checker (
    .clk_i, .sys_rst_i, .req_valid_i, .req_i, .feat_i, .float_control_register_i, .gpr_rd_data_i,
    .z_rd_data_i, .za_rd_data_i, .busy_o, .done_o, .undef_o, .trap_o, .flags_o,
    .gpr_rd_en_o, .gpr_rd_addr_o, .z_rd_en_o, .z_rd_addr_o, .za_rd_en_o, .za_rd_addr_o,
    .za_wr_en_o, .za_wr_addr_o, .z_wr_en_o, .z_wr_addr_o, .wr_data_o);
